// File: gcw_chk_properties.sv
// port assertions for the control word decoder
`timescale 1ns/1ps
`default_nettype none
module gcw_chk import gcw_pkg::*; #(parameter int NODES = 32) (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire gcw_wr_t          img_wr,
   input wire logic             words_enabled,
   input wire logic             exchange_en,
   input wire logic [NODES-1:0] node_enable,
   input wire logic             cmd_done,
   input wire logic [15:0]      host_control_word
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // accepted byte writes
   wire logic hi = img_wr.wr & words_enabled & (img_wr.addr == 10'h200);
   wire logic lo = img_wr.wr & words_enabled & (img_wr.addr == 10'h201);
   ////////////////////////////////////////////////////////////////
   property p_msb; hi |=> host_control_word[15:8] == $past(img_wr.data); endproperty
   a_msb: assert property (p_msb) else $error("msb lost");
   property p_lsb; lo |=> host_control_word[7:0] == $past(img_wr.data); endproperty
   a_lsb: assert property (p_lsb) else $error("lsb lost");
   property p_on; words_enabled && $rose(host_control_word[13]) |-> ##[1:2] exchange_en; endproperty
   a_on: assert property (p_on) else $error("no exchange");
   property p_off; words_enabled && $fell(host_control_word[13]) |-> ##[1:2] !exchange_en; endproperty
   a_off: assert property (p_off) else $error("exchange kept");
   property p_free; !words_enabled [*2] |-> exchange_en; endproperty
   a_free: assert property (p_free) else $error("gated");
   property p_ack; $changed(host_control_word[14]) |-> ##[1:3] cmd_done; endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_node; $changed(node_enable) |-> cmd_done; endproperty
   a_node: assert property (p_node) else $error("stray node change");
   property p_once; cmd_done |=> !cmd_done; endproperty
   a_once: assert property (p_once) else $error("long done");
   // main scenarios
   c_done: cover property (cmd_done);
   c_off: cover property (words_enabled && !exchange_en);
   c_free: cover property (!words_enabled && exchange_en);
endmodule : gcw_chk
bind gcw_decoder gcw_chk #(.NODES(NODES)) i_chk (.*);
`default_nettype wire

// File: gcw_decoder.sv
// gateway control word decoder: takes the control word, drives status and node enables
//
// What this block does
// - control word read from bytes 0x200-0x201
// - bit 15 host ack, bit 14 host request
// - exchange only while output-valid bit is one, always on while words disabled
// - output-valid honoured only when words enabled
// - execute bit set runs the coded command
// - code in bits 11:8, argument 7:0
// - word is big-endian, msb at lower offset
// - code 0x00 disables the addressed node
// - code 0x01 re-enables the addressed node
// - code 0x02 enables first n, disables rest
// - node commands only in polling master modes
// - free-frame mode supports no commands at all
// - status word presented at bytes 0x000-0x001
// - status bit 15 request, bit 14 ack
`timescale 1ns/1ps
`default_nettype none
module gcw_decoder
   import gcw_pkg::*;
#(
   parameter int NODES = 32  // configured sub-network nodes
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // process image writes from the control system
   input  wire gcw_wr_t          img_wr,
   // status word byte reads by the control system
   input  wire logic [9:0]       img_rd_addr,
   output logic      [7:0]       img_rd_data,
   // configuration
   input  wire logic             words_enabled,
   input  wire gcw_mode_t        mode,
   input  wire logic [7:0]       node_addr [NODES],
   // gateway status inputs
   input  wire logic             gw_req_flip,
   input  wire logic             gw_data_valid,
   input  wire logic [4:0]       gw_status_code,
   input  wire logic [7:0]       gw_status_data,
   // outputs to the sub-network engine
   output logic                  exchange_en,
   output logic [NODES-1:0]      node_enable,
   output logic                  cmd_done,
   output logic [15:0]           host_control_word
);

   // node index must fit the argument byte
   if (NODES < 1 || NODES > 255) begin : g_bad_nodes
      $error("NODES must be 1..255");
   end

   ////////////////////////////////////////////////////////////////////
   // process image capture of the control word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_control_word <= GCW_CTRL_RESET;
      end else if (img_wr.wr && words_enabled) begin
         if (img_wr.addr == GCW_CTRL_OFS_HI)
            host_control_word[15:8] <= img_wr.data;
         else if (img_wr.addr == GCW_CTRL_OFS_LO)
            host_control_word[7:0] <= img_wr.data;
      end
   end

   // field views
   logic     host_ack_toggle;
   logic     host_request_toggle;
   logic     out_valid;
   logic     exec_bit;
   gcw_cmd_t cmd;
   assign host_ack_toggle     = host_control_word[GCW_BIT_ACK];
   assign host_request_toggle = host_control_word[GCW_BIT_REQ];
   assign out_valid           = host_control_word[GCW_BIT_VALID];
   assign exec_bit            = host_control_word[GCW_BIT_EXEC];
   assign cmd.code = host_control_word[GCW_CODE_HI:GCW_CODE_LO];
   assign cmd.arg  = host_control_word[GCW_ARG_HI:GCW_ARG_LO];

   ////////////////////////////////////////////////////////////////////
   // sub-network exchange gate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         exchange_en <= 1'b0;
      else if (words_enabled)
         exchange_en <= out_valid;
      else
         exchange_en <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // handshake request detection
   logic req_seen;
   logic new_req;
   assign new_req = words_enabled && (host_request_toggle != req_seen);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         req_seen <= 1'b0;
      else if (new_req)
         req_seen <= host_request_toggle;
   end

   logic gw_ack_toggle;
   logic gw_request_toggle;

   // ack toggles once each request is processed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gw_ack_toggle <= 1'b0;
         cmd_done      <= 1'b0;
      end else begin
         cmd_done <= new_req;
         if (new_req)
            gw_ack_toggle <= ~gw_ack_toggle;
      end
   end

   // gateway request flips on its own events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         gw_request_toggle <= 1'b0;
      else if (gw_req_flip)
         gw_request_toggle <= ~gw_request_toggle;
   end

   ////////////////////////////////////////////////////////////////////
   // node command execution
   logic polling_mode;
   logic run_cmd;
   assign polling_mode = (mode == GCW_MODE_MASTER) || (mode == GCW_MODE_ALT_MASTER);
   assign run_cmd      = new_req && exec_bit && polling_mode;

   // node address match, shared by disable and enable
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : addr_hit

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         node_enable <= '1;
      end else if (run_cmd) begin
         for (int i = 0; i < NODES; i++) begin
            unique case (cmd.code)
               GCW_CMD_DISABLE:
                  if (addr_hit(node_addr[i], cmd.arg)) node_enable[i] <= 1'b0;
               GCW_CMD_ENABLE:
                  if (addr_hit(node_addr[i], cmd.arg)) node_enable[i] <= 1'b1;
               GCW_CMD_ENABLE_N:
                  node_enable[i] <= (i < int'(cmd.arg));
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status word read mux, msb first
   logic [15:0] status_word;
   assign status_word = {gw_request_toggle, gw_ack_toggle, gw_data_valid,
                         gw_status_code, gw_status_data};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         img_rd_data <= 8'h00;
      else if (!words_enabled)
         img_rd_data <= 8'h00;
      else if (img_rd_addr == GCW_STAT_OFS_HI)
         img_rd_data <= status_word[15:8];
      else if (img_rd_addr == GCW_STAT_OFS_LO)
         img_rd_data <= status_word[7:0];
      else
         img_rd_data <= 8'h00;
   end

endmodule : gcw_decoder
`default_nettype wire

// File: gcw_host.sv
// control system model writing the process image
`timescale 1ns/1ps
`default_nettype none
module gcw_host import gcw_pkg::*; (
   input  wire logic    clk,
   output var gcw_wr_t  img_wr
);
   // lsb then msb pulse, junk on the idle bus
   task automatic word(input logic [15:0] w);
      @(negedge clk) img_wr = {1'h1, 10'h201, w[7:0]};
      @(negedge clk) img_wr = {1'h1, 10'h200, w[15:8]};
      @(negedge clk) img_wr = {1'h0, 10'h3FF, ~w[7:0]};
   endtask : word
   initial img_wr = '0;
endmodule : gcw_host
`default_nettype wire

// File: gcw_pkg.sv
// constants and carrier types for the gateway control word decoder
package gcw_pkg;
   // byte offsets in the process image
   localparam logic [9:0] GCW_CTRL_OFS_HI   = 10'h200; // msb of control word
   localparam logic [9:0] GCW_CTRL_OFS_LO   = 10'h201;
   localparam logic [9:0] GCW_STAT_OFS_HI   = 10'h000; // msb of status word
   localparam logic [9:0] GCW_STAT_OFS_LO   = 10'h001;
   // control word fields
   localparam int GCW_BIT_ACK    = 15;
   localparam int GCW_BIT_REQ    = 14;
   localparam int GCW_BIT_VALID  = 13;
   localparam int GCW_BIT_EXEC   = 12;
   localparam int GCW_CODE_HI    = 11;
   localparam int GCW_CODE_LO    = 8;
   localparam int GCW_ARG_HI     = 7;
   localparam int GCW_ARG_LO     = 0;
   localparam logic [15:0] GCW_CTRL_RESET = 16'h0000;
   // command codes
   localparam logic [3:0] GCW_CMD_DISABLE  = 4'h0;
   localparam logic [3:0] GCW_CMD_ENABLE   = 4'h1;
   localparam logic [3:0] GCW_CMD_ENABLE_N = 4'h2;
   // operating modes
   typedef enum logic [1:0] {
      GCW_MODE_MASTER     = 2'h0,
      GCW_MODE_ALT_MASTER = 2'h1,  // alt_protocol_master_mode
      GCW_MODE_FREE_FRAME = 2'h2
   } gcw_mode_t;
   // process image byte write
   typedef struct packed {
      logic       wr;
      logic [9:0] addr;
      logic [7:0] data;
   } gcw_wr_t;
   // decoded command
   typedef struct packed {
      logic [3:0] code;
      logic [7:0] arg;
   } gcw_cmd_t;
endpackage : gcw_pkg

// File: tb.sv
// bench for the control word decoder
`timescale 1ns/1ps
`default_nettype none
module tb import gcw_pkg::*;;
   logic       clk = 1'h0, rst_n = 1'h0, we = 1'h1, rq = 1'h0, ex, dn;
   logic [7:0] rd, na [4] = '{8'h10, 8'h11, 8'h12, 8'h13};
   logic [9:0] ra = 10'h001;
   logic       gf = 1'h0, gv = 1'h0;
   logic [3:0] ne;
   gcw_mode_t  md = GCW_MODE_MASTER;
   gcw_wr_t    wr;
   int         n_mismatch = 0, total_checks = 0;
   // clock, host model and design
   initial forever #20 clk = ~clk;
   gcw_host i_gcw_host (.clk(clk), .img_wr(wr));
   gcw_decoder #(.NODES(4)) i_gcw_decoder (.clk(clk), .rst_n(rst_n), .img_wr(wr), .mode(md),
      .img_rd_addr(ra), .img_rd_data(rd), .words_enabled(we), .node_addr(na), .gw_req_flip(gf),
      .gw_data_valid(gv), .gw_status_code(5'h00), .gw_status_data(8'h5A), .exchange_en(ex),
      .node_enable(ne), .cmd_done(dn), .host_control_word());
   // compare one value
   task automatic chk(input string s, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) n_mismatch++;
      if (g !== e) $display("unexpected %s expected %h seen %h", s, e, g);
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // one request with a bounded wait, then node check
   task automatic cmd(input logic [15:0] w, input logic [3:0] n);
      int k;
      rq = ~rq;
      i_gcw_host.word(w | {1'h0, rq, 14'h0});
      for (k = 0; k < 8 && dn !== 1'h1; k++) @(negedge clk);
      chk("done", 8'h1, 8'(dn));
      if (k == 8) close_out();
      @(negedge clk);
      chk("nodes", {4'h0, n}, {4'h0, ne});
   endtask : cmd
   task automatic t_cmds;
      chk("exchange", 8'h0, 8'(ex));
      cmd(16'h3012, 4'hB);
      chk("exchange", 8'h1, 8'(ex));
      cmd(16'h3112, 4'hF);
      md = GCW_MODE_ALT_MASTER;
      cmd(16'h3203, 4'h7);
      cmd(16'h2010, 4'h7);
      md = GCW_MODE_FREE_FRAME;
      cmd(16'h1010, 4'h7);
      $display("command test done");
   endtask : t_cmds
   task automatic t_gate;
      chk("exchange", 8'h0, 8'(ex));
      we = 1'h0;
      repeat (2) @(negedge clk);
      chk("exchange", 8'h1, 8'(ex));
      we = 1'h1;
      repeat (2) @(negedge clk);
      chk("status lsb", 8'h5A, rd);
      ra = 10'h000;
      repeat (2) @(negedge clk);
      chk("status msb", {1'h0, rq, 6'h00}, rd);
      gf = 1'h1;
      gv = 1'h1;
      @(negedge clk);
      gf = 1'h0;
      repeat (2) @(negedge clk);
      chk("status msb", {1'h1, rq, 1'h1, 5'h00}, rd);
      $display("gate and status test done");
   endtask : t_gate
   // reset, scenarios, verdict
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'h1;
      @(negedge clk);
      t_cmds();
      t_gate();
      close_out();
   end
endmodule : tb
`default_nettype wire
